// File: usbdc_defs.svh
// Constants shared by both ends of the USB packet DMA support logic.
`ifndef USBDC_DEFS_SVH
`define USBDC_DEFS_SVH
`define USBDC_REGIONS 16
`define USBDC_CHANS 4
`define USBDC_TABLE_DEPTH 256
`define USBDC_LINK_ENTRIES 64
`define USBDC_FIFO_DEPTH 32
`define USBDC_Q_TXCMP0 6'h18
`define USBDC_Q_RXCMP1 6'h1B
`define USBDC_SEL_REGION 3'h0
`define USBDC_SEL_LINK 3'h1
`define USBDC_SEL_TABLE 3'h2
`define USBDC_SEL_SCHED 3'h3
`define USBDC_SEL_CHEN 3'h4
`define USBDC_SEL_TXST 3'h5
`define USBDC_SEL_RXST 3'h6
`define USBDC_RF_BASE 2'h0
`define USBDC_RF_FIRST 2'h1
`define USBDC_RF_SIZE 2'h2
`define USBDC_RF_BANK 2'h3
`define USBDC_SCHED_EN_BIT 0
`define USBDC_LAST_LSB 8
`define USBDC_LAST_MSB 15
`endif

// File: usbdc_pkg.sv
// Types shared by both ends of the USB packet DMA support logic.
package usbdc_pkg;
  typedef enum logic [1:0] {
    USBDC_IDLE = 2'h0,
    USBDC_EVAL = 2'h1,
    USBDC_OFFER = 2'h3
  } usbdc_sched_e;
  typedef struct packed {
    logic rx;
    logic [1:0] chan;
  } usbdc_entry_s;
  typedef logic [36:0] usbdc_blk_t;
endpackage

// File: usbdc_if.sv
// Link between the packet DMA end and the USB endpoint FIFO end.
`timescale 1ns/1ps
interface usbdc_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [3:0] fifo_full;
  logic [3:0] fifo_empty;
  logic credit_valid;
  logic credit_ready;
  logic [1:0] credit_chan;
  logic credit_rx;
  logic blk_valid;
  logic blk_ready;
  logic [31:0] blk_data;
  logic [2:0] blk_len;
  logic blk_eop;
  logic blk_zlp;
  logic tx_valid;
  logic tx_ready;
  logic [1:0] tx_chan;
  logic [31:0] tx_data;
  logic [2:0] tx_len;
  logic tx_eop;
  logic tx_zlp;
  modport dev (
    input fifo_full, fifo_empty, credit_ready, blk_valid, blk_data,
    input blk_len, blk_eop, blk_zlp, tx_ready,
    output credit_valid, credit_chan, credit_rx, blk_ready, tx_valid,
    output tx_chan, tx_data, tx_len, tx_eop, tx_zlp
  );
  modport ptr (
    output fifo_full, fifo_empty, credit_ready, blk_valid, blk_data,
    output blk_len, blk_eop, blk_zlp, tx_ready,
    input credit_valid, credit_chan, credit_rx, blk_ready, tx_valid,
    input tx_chan, tx_data, tx_len, tx_eop, tx_zlp
  );
endinterface

// File: usbdc_device.sv
// Packet DMA end: regions, linking memory, scheduler, state and receive FIFO.
`timescale 1ns/1ps
`include "usbdc_defs.svh"

module usbdc_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = `USBDC_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

module usbdc_device
  import usbdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the USB endpoint FIFO end.
  usbdc_if.dev lnk,
  // Host configuration port.
  input wire logic cfg_we,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // Descriptor address and link lookup.
  input wire logic [3:0] q_region,
  input wire logic [15:0] q_index,
  output logic [31:0] q_addr,
  output logic [15:0] q_next,
  // Transmit blocks from the host.
  input wire logic htx_valid,
  output logic htx_ready,
  input wire logic [1:0] htx_chan,
  input wire logic [31:0] htx_data,
  input wire logic [2:0] htx_len,
  input wire logic htx_eop,
  input wire logic htx_zlp,
  // Received data toward the host.
  output logic hrx_valid,
  input wire logic hrx_ready,
  output logic [31:0] hrx_data,
  output logic pkt_done,
  output logic [15:0] pkt_bytes,
  output logic pkt_zlp,
  // Completions and interrupt.
  input wire logic cmp_valid,
  input wire logic [5:0] cmp_queue,
  output logic dma_irq
);
  logic [31:0] reg_base_ff [`USBDC_REGIONS];
  logic [15:0] reg_first_ff [`USBDC_REGIONS];
  logic [3:0] reg_size_ff [`USBDC_REGIONS];
  logic reg_bank_ff [`USBDC_REGIONS];
  logic [15:0] link_ff [2][`USBDC_LINK_ENTRIES];
  usbdc_entry_s table_ff [`USBDC_TABLE_DEPTH];
  logic sched_en_ff;
  logic [7:0] last_ff;
  logic [3:0] chan_en_ff;
  logic [31:0] txst_ff [`USBDC_CHANS][5];
  logic [31:0] rxst_ff [`USBDC_CHANS][3];
  usbdc_sched_e state_ff;
  logic [7:0] idx_ff;
  usbdc_entry_s cur_ff;
  logic [15:0] acc_ff;
  logic txs_valid_ff;
  logic [36:0] txs_ff;
  logic [1:0] txs_chan_ff;
  logic f_valid;
  usbdc_blk_t f_data;
  logic f_pop;
  logic eligible;

  // Region lookup turns an index into a byte address within its region.
  function automatic logic [31:0] desc_addr(input logic [31:0] base,
      input logic [15:0] first, input logic [3:0] sz, input logic [15:0] i);
    logic [31:0] off;
    off = {16'h0000, i - first};
    desc_addr = base + (off << sz);
  endfunction

  function automatic logic [7:0] next_idx(input logic [7:0] i,
      input logic [7:0] last);
    next_idx = (i == last) ? 8'h00 : i + 8'h01;
  endfunction

  // Configuration writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sched_en_ff <= 1'b0;
      last_ff <= 8'hFF;
      chan_en_ff <= 4'h0;
      for (int r = 0; r < `USBDC_REGIONS; r++) begin
        reg_base_ff[r] <= 32'h00000000;
        reg_first_ff[r] <= 16'h0000;
        reg_size_ff[r] <= 4'h0;
        reg_bank_ff[r] <= 1'b0;
      end
    end else if (cfg_we) begin
      if (cfg_sel == `USBDC_SEL_REGION) begin
        case (cfg_addr[5:4])
          `USBDC_RF_BASE: reg_base_ff[cfg_addr[3:0]] <= cfg_wdata;
          `USBDC_RF_FIRST: reg_first_ff[cfg_addr[3:0]] <= cfg_wdata[15:0];
          `USBDC_RF_SIZE: reg_size_ff[cfg_addr[3:0]] <= cfg_wdata[3:0];
          default: reg_bank_ff[cfg_addr[3:0]] <= cfg_wdata[0];
        endcase
      end else if (cfg_sel == `USBDC_SEL_SCHED) begin
        sched_en_ff <= cfg_wdata[`USBDC_SCHED_EN_BIT];
        last_ff <= cfg_wdata[`USBDC_LAST_MSB:`USBDC_LAST_LSB];
      end else if (cfg_sel == `USBDC_SEL_CHEN) begin
        chan_en_ff <= cfg_wdata[3:0];
      end
    end
  end

  // Table and linking memories; the table takes writes at any time.
  always_ff @(posedge clk) begin
    if (cfg_we && cfg_sel == `USBDC_SEL_TABLE) begin
      table_ff[cfg_addr] <= cfg_wdata[2:0];
    end
    if (cfg_we && cfg_sel == `USBDC_SEL_LINK) begin
      link_ff[cfg_addr[6]][cfg_addr[5:0]] <= cfg_wdata[15:0];
    end
  end

  // Per-channel transmit and receive state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int c = 0; c < `USBDC_CHANS; c++) begin
        for (int f = 0; f < 5; f++) begin
          txst_ff[c][f] <= 32'h00000000;
        end
        for (int f = 0; f < 3; f++) begin
          rxst_ff[c][f] <= 32'h00000000;
        end
      end
    end else if (cfg_we && cfg_sel == `USBDC_SEL_TXST && cfg_addr[4:2] < 3'h5)
    begin
      txst_ff[cfg_addr[1:0]][cfg_addr[4:2]] <= cfg_wdata;
    end else if (cfg_we && cfg_sel == `USBDC_SEL_RXST && cfg_addr[3:2] < 2'h3)
    begin
      rxst_ff[cfg_addr[1:0]][cfg_addr[3:2]] <= cfg_wdata;
    end
  end

  // Reads; the table answers zero so its contents never leave.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_rd) begin
      if (cfg_sel == `USBDC_SEL_REGION) begin
        case (cfg_addr[5:4])
          `USBDC_RF_BASE: cfg_rdata <= reg_base_ff[cfg_addr[3:0]];
          `USBDC_RF_FIRST: cfg_rdata <= {16'h0000,
              reg_first_ff[cfg_addr[3:0]]};
          `USBDC_RF_SIZE: cfg_rdata <= {28'h0000000,
              reg_size_ff[cfg_addr[3:0]]};
          default: cfg_rdata <= {31'h00000000, reg_bank_ff[cfg_addr[3:0]]};
        endcase
      end else if (cfg_sel == `USBDC_SEL_SCHED) begin
        cfg_rdata <= {8'h00, idx_ff, last_ff, 7'h00, sched_en_ff};
      end else if (cfg_sel == `USBDC_SEL_CHEN) begin
        cfg_rdata <= {28'h0000000, chan_en_ff};
      end else if (cfg_sel == `USBDC_SEL_TXST && cfg_addr[4:2] < 3'h5) begin
        cfg_rdata <= txst_ff[cfg_addr[1:0]][cfg_addr[4:2]];
      end else if (cfg_sel == `USBDC_SEL_RXST && cfg_addr[3:2] < 2'h3) begin
        cfg_rdata <= rxst_ff[cfg_addr[1:0]][cfg_addr[3:2]];
      end else begin
        cfg_rdata <= 32'h00000000;
      end
    end
  end

  // Descriptor address and next-index lookup, one cycle after the query.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_addr <= 32'h00000000;
      q_next <= 16'h0000;
    end else begin
      q_addr <= desc_addr(reg_base_ff[q_region], reg_first_ff[q_region],
          reg_size_ff[q_region], q_index);
      q_next <= link_ff[reg_bank_ff[q_region]][q_index[5:0]];
    end
  end

  // Scheduler.
  assign eligible = chan_en_ff[cur_ff.chan] && (cur_ff.rx ?
      !lnk.fifo_empty[cur_ff.chan] : !lnk.fifo_full[cur_ff.chan]);
  assign lnk.credit_valid = (state_ff == USBDC_OFFER);
  assign lnk.credit_chan = cur_ff.chan;
  assign lnk.credit_rx = cur_ff.rx;

  always_ff @(posedge clk) begin
    if (!rst_n || !sched_en_ff) begin
      state_ff <= USBDC_IDLE;
      idx_ff <= 8'h00;
      cur_ff <= '0;
    end else begin
      case (state_ff)
        USBDC_IDLE: begin
          cur_ff <= table_ff[idx_ff];
          state_ff <= USBDC_EVAL;
        end
        USBDC_EVAL: begin
          if (eligible) begin
            state_ff <= USBDC_OFFER;
          end else begin
            idx_ff <= next_idx(idx_ff, last_ff);
            state_ff <= USBDC_IDLE;
          end
        end
        USBDC_OFFER: begin
          // Stalls here until the far end is idle and takes the credit.
          if (lnk.credit_ready) begin
            idx_ff <= next_idx(idx_ff, last_ff);
            state_ff <= USBDC_IDLE;
          end
        end
        default: state_ff <= USBDC_IDLE;
      endcase
    end
  end

  // Transmit slot; one block is held until the far end takes it.
  assign htx_ready = !txs_valid_ff;
  assign lnk.tx_valid = txs_valid_ff;
  assign lnk.tx_chan = txs_chan_ff;
  assign lnk.tx_data = txs_ff[36:5];
  assign lnk.tx_len = txs_ff[4:2];
  assign lnk.tx_eop = txs_ff[1];
  assign lnk.tx_zlp = txs_ff[0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txs_valid_ff <= 1'b0;
      txs_ff <= '0;
      txs_chan_ff <= 2'h0;
    end else if (htx_valid && !txs_valid_ff) begin
      txs_valid_ff <= 1'b1;
      txs_ff <= {htx_data, htx_len, htx_eop, htx_zlp};
      txs_chan_ff <= htx_chan;
    end else if (lnk.tx_ready) begin
      txs_valid_ff <= 1'b0;
    end
  end

  // Receive path; the host's ready stalls the FIFO and then the link.
  usbdc_fifo #(.WIDTH(37), .DEPTH(`USBDC_FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(lnk.blk_valid),
    .in_ready(lnk.blk_ready),
    .in_data({lnk.blk_data, lnk.blk_len, lnk.blk_eop, lnk.blk_zlp}),
    .out_valid(f_valid),
    .out_ready(hrx_ready || !hrx_valid),
    .out_data(f_data)
  );
  assign f_pop = f_valid && (hrx_ready || !hrx_valid);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrx_valid <= 1'b0;
      hrx_data <= 32'h00000000;
      acc_ff <= 16'h0000;
      pkt_done <= 1'b0;
      pkt_bytes <= 16'h0000;
      pkt_zlp <= 1'b0;
    end else begin
      pkt_done <= f_pop && f_data[1];
      if (hrx_valid && hrx_ready) begin
        hrx_valid <= 1'b0;
      end
      if (f_pop) begin
        // A flagged zero-length block only closes the packet.
        if (!f_data[0] && f_data[4:2] != 3'h0) begin
          hrx_valid <= 1'b1;
          hrx_data <= f_data[36:5];
        end
        if (f_data[1] || f_data[0]) begin
          pkt_bytes <= acc_ff + {13'h0000, f_data[0] ? 3'h0 : f_data[4:2]};
          pkt_zlp <= f_data[0];
          pkt_done <= 1'b1;
          acc_ff <= 16'h0000;
        end else begin
          acc_ff <= acc_ff + {13'h0000, f_data[4:2]};
        end
      end
    end
  end

  // Completion interrupt; no mask stands in its way.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_irq <= 1'b0;
    end else begin
      dma_irq <= cmp_valid && cmp_queue >= `USBDC_Q_TXCMP0 &&
          cmp_queue <= `USBDC_Q_RXCMP1;
    end
  end
endmodule

// File: usbdc_partner.sv
// USB endpoint FIFO end: takes credits, moves blocks, handles null packets.
`timescale 1ns/1ps
`include "usbdc_defs.svh"

module usbdc_partner
  import usbdc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the packet DMA end.
  usbdc_if.ptr lnk,
  // Packets received from USB.
  input wire logic urx_valid,
  output logic urx_ready,
  input wire logic [1:0] urx_chan,
  input wire logic [31:0] urx_data,
  input wire logic [2:0] urx_len,
  input wire logic urx_last,
  // Packets sent to USB.
  output logic utx_valid,
  input wire logic utx_ready,
  output logic [1:0] utx_chan,
  output logic [31:0] utx_data,
  output logic [2:0] utx_len,
  output logic utx_last
);
  logic busy_ff;
  logic busy_rx_ff;
  logic [1:0] busy_chan_ff;
  logic rxh_valid_ff;
  logic [1:0] rxh_chan_ff;
  logic [31:0] rxh_data_ff;
  logic [2:0] rxh_len_ff;
  logic rxh_last_ff;
  logic blk_take;
  logic tx_take;

  // Credits are taken only while idle, so one is in flight at a time.
  assign lnk.credit_ready = !busy_ff;
  assign urx_ready = !rxh_valid_ff;
  assign lnk.blk_valid = busy_ff && busy_rx_ff && rxh_valid_ff;
  assign lnk.blk_data = rxh_data_ff;
  assign lnk.blk_len = rxh_len_ff;
  assign lnk.blk_zlp = (rxh_len_ff == 3'h0);
  assign lnk.blk_eop = rxh_last_ff || (rxh_len_ff == 3'h0);
  assign lnk.tx_ready = busy_ff && !busy_rx_ff && !utx_valid &&
      lnk.tx_valid && lnk.tx_chan == busy_chan_ff;
  assign blk_take = lnk.blk_valid && lnk.blk_ready;
  assign tx_take = lnk.tx_ready;

  always_comb begin
    for (int c = 0; c < `USBDC_CHANS; c++) begin
      lnk.fifo_empty[c] = !(rxh_valid_ff && rxh_chan_ff == c[1:0]);
      lnk.fifo_full[c] = utx_valid;
    end
  end

  // Credit ownership; an empty transmit credit is returned at once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      busy_rx_ff <= 1'b0;
      busy_chan_ff <= 2'h0;
    end else if (!busy_ff && lnk.credit_valid) begin
      busy_ff <= 1'b1;
      busy_rx_ff <= lnk.credit_rx;
      busy_chan_ff <= lnk.credit_chan;
    end else if (blk_take || tx_take) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && !busy_rx_ff &&
        !(lnk.tx_valid && lnk.tx_chan == busy_chan_ff)) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && busy_rx_ff && !rxh_valid_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // Receive staging word, one shared by all four channels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxh_valid_ff <= 1'b0;
      rxh_chan_ff <= 2'h0;
      rxh_data_ff <= 32'h00000000;
      rxh_len_ff <= 3'h0;
      rxh_last_ff <= 1'b0;
    end else if (urx_valid && !rxh_valid_ff) begin
      rxh_valid_ff <= 1'b1;
      rxh_chan_ff <= urx_chan;
      rxh_data_ff <= urx_data;
      rxh_len_ff <= urx_len;
      rxh_last_ff <= urx_last;
    end else if (blk_take) begin
      rxh_valid_ff <= 1'b0;
    end
  end

  // Transmit toward USB; a flagged block overrides the byte count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      utx_valid <= 1'b0;
      utx_chan <= 2'h0;
      utx_data <= 32'h00000000;
      utx_len <= 3'h0;
      utx_last <= 1'b0;
    end else if (tx_take) begin
      utx_valid <= 1'b1;
      utx_chan <= lnk.tx_chan;
      utx_data <= lnk.tx_zlp ? 32'h00000000 : lnk.tx_data;
      utx_len <= lnk.tx_zlp ? 3'h0 : lnk.tx_len;
      utx_last <= lnk.tx_eop || lnk.tx_zlp;
    end else if (utx_ready) begin
      utx_valid <= 1'b0;
    end
  end
endmodule

// File: usbdc_assertions.sv
// Checker that watches the link between the two ends.
`timescale 1ns/1ps
module usbdc_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Credit path.
  input wire logic [3:0] fifo_full,
  input wire logic [3:0] fifo_empty,
  input wire logic credit_valid,
  input wire logic credit_ready,
  input wire logic [1:0] credit_chan,
  input wire logic credit_rx,
  // Block paths.
  input wire logic blk_valid,
  input wire logic [2:0] blk_len,
  input wire logic blk_eop,
  input wire logic blk_zlp,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic [2:0] tx_len,
  input wire logic tx_zlp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Flags are sampled one cycle back, when the entry was evaluated.
  a_rx_credit_elig: assert property (
    $rose(credit_valid) && credit_rx |-> !$past(fifo_empty[credit_chan]))
    else $error("rx credit offered to an empty fifo");
  a_tx_credit_elig: assert property (
    $rose(credit_valid) && !credit_rx |-> !$past(fifo_full[credit_chan]))
    else $error("tx credit offered to a full fifo");
  a_credit_held: assert property (
    credit_valid && !credit_ready |=> credit_valid && $stable(credit_chan)
    && $stable(credit_rx))
    else $error("credit dropped or changed while stalled");
  a_credit_advance: assert property (
    credit_valid && credit_ready |=> !credit_valid [*2])
    else $error("no fresh evaluation after credit taken");
  a_entry_spacing: assert property (
    $rose(credit_valid) |-> !$past(credit_valid, 2))
    else $error("credit offered without load and evaluate");
  a_zlp_block: assert property (
    blk_valid && blk_zlp |-> blk_len == 3'h0 && blk_eop)
    else $error("null block without zero count and end mark");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable(tx_len) && $stable(tx_zlp))
    else $error("tx block changed before it was taken");
  a_reset_idle: assert property (
    $rose(rst_n) |-> fifo_empty == 4'hF && fifo_full == 4'h0
    && credit_ready && !credit_valid)
    else $error("link not idle after reset");
endmodule

// File: test_usb_dma_credit_scheduler.sv
// Testbench joining both ends across the link.
`timescale 1ns/1ps
module test_usb_dma_credit_scheduler;
  logic clk = 0, rst_n = 0;
  logic cfg_we = 0, cfg_rd = 0, htx_valid = 0, htx_eop = 0, htx_zlp = 0;
  logic [2:0] cfg_sel = 0, htx_len = 0, urx_len = 0;
  logic [7:0] cfg_addr = 0;
  logic [31:0] cfg_wdata = 0, htx_data = 0, urx_data = 0, cfg_rdata;
  logic [3:0] q_region = 0;
  logic [15:0] q_index = 0, q_next, pkt_bytes;
  logic [1:0] htx_chan = 0, urx_chan = 0, utx_chan;
  logic hrx_ready = 1, cmp_valid = 0, urx_valid = 0, urx_last = 0;
  logic utx_ready = 1, htx_ready, hrx_valid, pkt_done, pkt_zlp, dma_irq;
  logic urx_ready, utx_valid, utx_last;
  logic [5:0] cmp_queue = 0;
  logic [31:0] q_addr, hrx_data, utx_data, last_rx, ut_data, d;
  logic [2:0] utx_len;
  logic [5:0] ut_f;
  logic [15:0] pd_bytes;
  logic pd_zlp;
  int n_errors = 0, samples_checked = 0, n_rx = 0, pd_n = 0, ut_n = 0;
  int stalled = 0, ns = 0, n_last = 0;
  // Ordinary rows: write, then read back what the map should return.
  logic [2:0] r_sel [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h5,
    3'h6, 3'h7};
  logic [7:0] r_adr [9] = '{8'h03, 8'h13, 8'h23, 8'h0F, 8'h05, 8'h00,
    8'h13, 8'h09, 8'h00};
  logic [31:0] r_wd [9] = '{32'h1000, 32'h10, 32'h5, 32'h2000, 32'h7,
    32'hF, 32'hCAFE, 32'h44, 32'h1};
  logic [31:0] r_exp [9] = '{32'h1000, 32'h10, 32'h5, 32'h2000, 32'h0,
    32'hF, 32'hCAFE, 32'h44, 32'h0};
  always #2.5 clk = ~clk;
  usbdc_if u_usbdc_if (.clk(clk), .rst_n(rst_n));
  usbdc_device u_usbdc_device (.clk(clk), .rst_n(rst_n), .lnk(u_usbdc_if),
    .cfg_we(cfg_we), .cfg_rd(cfg_rd), .cfg_sel(cfg_sel),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .q_region(q_region), .q_index(q_index), .q_addr(q_addr),
    .q_next(q_next), .htx_valid(htx_valid), .htx_ready(htx_ready),
    .htx_chan(htx_chan), .htx_data(htx_data), .htx_len(htx_len),
    .htx_eop(htx_eop), .htx_zlp(htx_zlp), .hrx_valid(hrx_valid),
    .hrx_ready(hrx_ready), .hrx_data(hrx_data), .pkt_done(pkt_done),
    .pkt_bytes(pkt_bytes), .pkt_zlp(pkt_zlp), .cmp_valid(cmp_valid),
    .cmp_queue(cmp_queue), .dma_irq(dma_irq));
  usbdc_partner u_usbdc_partner (.clk(clk), .rst_n(rst_n),
    .lnk(u_usbdc_if), .urx_valid(urx_valid), .urx_ready(urx_ready),
    .urx_chan(urx_chan), .urx_data(urx_data), .urx_len(urx_len),
    .urx_last(urx_last), .utx_valid(utx_valid), .utx_ready(utx_ready),
    .utx_chan(utx_chan), .utx_data(utx_data), .utx_len(utx_len),
    .utx_last(utx_last));
  usbdc_assertions u_usbdc_assertions (.clk(clk), .rst_n(rst_n),
    .fifo_full(u_usbdc_if.fifo_full), .fifo_empty(u_usbdc_if.fifo_empty),
    .credit_valid(u_usbdc_if.credit_valid),
    .credit_ready(u_usbdc_if.credit_ready),
    .credit_chan(u_usbdc_if.credit_chan), .credit_rx(u_usbdc_if.credit_rx),
    .blk_valid(u_usbdc_if.blk_valid), .blk_len(u_usbdc_if.blk_len),
    .blk_eop(u_usbdc_if.blk_eop), .blk_zlp(u_usbdc_if.blk_zlp),
    .tx_valid(u_usbdc_if.tx_valid), .tx_ready(u_usbdc_if.tx_ready),
    .tx_data(u_usbdc_if.tx_data), .tx_len(u_usbdc_if.tx_len),
    .tx_zlp(u_usbdc_if.tx_zlp));
  always @(posedge clk) begin
    if (hrx_valid && hrx_ready) begin
      n_rx++;
      last_rx = hrx_data;
    end
    if (pkt_done) begin
      pd_n++;
      pd_bytes = pkt_bytes;
      pd_zlp = pkt_zlp;
    end
    if (utx_valid && utx_ready) begin
      ut_n++;
      ut_data = utx_data;
      ut_f = {utx_chan, utx_len, utx_last};
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cw(input logic [2:0] s, input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    cfg_we <= 1;
    cfg_sel <= s;
    cfg_addr <= a;
    cfg_wdata <= w;
    @(posedge clk);
    cfg_we <= 0;
  endtask
  task cr(input logic [2:0] s, input logic [7:0] a);
    @(posedge clk);
    cfg_rd <= 1;
    cfg_sel <= s;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 0;
    #1 d = cfg_rdata;
  endtask
  // A stalled sender opens the host drain, so a full buffer cannot hang.
  task usend(input logic [1:0] c, input logic [31:0] v, input logic [2:0] l,
      input logic la);
    int i;
    @(posedge clk);
    urx_valid <= 1;
    urx_chan <= c;
    urx_data <= v;
    urx_len <= l;
    urx_last <= la;
    i = 0;
    @(posedge clk);
    while (!urx_ready && i < 600) begin
      if (i == 300) begin
        stalled++;
        hrx_ready <= 1;
      end
      @(posedge clk);
      i++;
    end
    urx_valid <= 0;
  endtask
  task hsend(input logic [31:0] v, input logic z);
    int i;
    @(posedge clk);
    htx_valid <= 1;
    htx_chan <= 2'h2;
    htx_data <= v;
    htx_len <= 3'h4;
    htx_eop <= 1;
    htx_zlp <= z;
    i = 0;
    @(posedge clk);
    while (!htx_ready && i < 300) begin
      @(posedge clk);
      i++;
    end
    htx_valid <= 0;
  endtask
  task wcnt(input int t, input bit u);
    int i;
    i = 0;
    while ((u ? ut_n : pd_n) < t && i < 500) begin
      @(posedge clk);
      i++;
    end
  endtask
  task close_out;
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 chk("reset", 32'h7C30, {u_usbdc_if.credit_ready,
      u_usbdc_if.fifo_empty, u_usbdc_if.fifo_full, htx_ready, urx_ready,
      dma_irq, hrx_valid, utx_valid, u_usbdc_if.credit_valid});
    for (int k = 0; k < 9; k++) begin
      cw(r_sel[k], r_adr[k], r_wd[k]);
      cr(r_sel[k], r_adr[k]);
      chk("cfg", r_exp[k], d);
    end
    cw(3'h1, 8'h45, 32'h0ABC);
    cw(3'h0, 8'h33, 32'h1);
    @(posedge clk);
    q_region <= 4'h3;
    q_index <= 16'h0013;
    repeat (2) @(posedge clk);
    #1 chk("q_addr", 32'h1060, q_addr);
    @(posedge clk);
    q_index <= 16'h0005;
    repeat (2) @(posedge clk);
    #1 chk("q_next", 32'h0ABC, q_next);
    for (int q = 0; q < 64; q++) begin
      @(posedge clk);
      cmp_valid <= 1;
      cmp_queue <= q[5:0];
      @(posedge clk);
      cmp_valid <= 0;
      #1 chk("dma_irq", q >= 24 && q <= 27, dma_irq);
    end
    cw(3'h3, 8'h00, 32'h0301);
    for (int k = 0; k < 12; k++) begin
      cr(3'h3, 8'h00);
      chk("index_wrap", 1, d[23:16] <= 8'h03);
      if (d[23:16] == 8'h03)
        n_last++;
    end
    // Seeing the final slot twice proves the index came round again.
    chk("index_last", 1, n_last >= 2);
    cw(3'h3, 8'h00, 32'h0300);
    cr(3'h3, 8'h00);
    chk("index_off", 0, d[23:16]);
    cw(3'h3, 8'h00, 32'h0301);
    cr(3'h3, 8'h00);
    chk("index_start", 0, d[23:16]);
    // Table rewritten while the scheduler keeps running.
    for (int k = 0; k < 4; k++)
      cw(3'h2, k[7:0], k[0] ? 32'h2 : 32'h5);
    cw(3'h4, 8'h00, 32'h6);
    usend(2'h1, 32'h11111111, 3'h4, 0);
    usend(2'h1, 32'h22222222, 3'h4, 1);
    wcnt(1, 0);
    chk("pkt_bytes", 8, pd_bytes);
    chk("rx_data", 32'h22222222, last_rx);
    usend(2'h1, 32'h0, 3'h0, 1);
    wcnt(2, 0);
    chk("zlp_pkt", 32'h10000, {pd_zlp, pd_bytes});
    chk("zlp_words", 2, n_rx);
    hsend(32'hA5A5A5A5, 0);
    wcnt(1, 1);
    chk("utx", 32'hA5A5A5A5, ut_data);
    chk("utx_f", 6'h29, ut_f);
    hsend(32'h5A5A5A5A, 1);
    wcnt(2, 1);
    chk("utx_zlp", 32'h0, ut_data);
    chk("utx_zlp_f", 32'h21, ut_f);
    @(posedge clk);
    hrx_ready <= 0;
    for (int k = 0; k < 40; k++) begin
      usend(2'h1, k, 3'h4, k == 39);
      if (stalled == 1 && ns == 0)
        ns = k;
    end
    wcnt(3, 0);
    chk("fill_stall", 1, stalled == 1 && ns >= 32);
    chk("fill_words", 42, n_rx);
    chk("fill_bytes", 160, pd_bytes);
    // A reset in mid-run must bring both ends back to idle.
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 chk("reset_again", 32'h7C30, {u_usbdc_if.credit_ready,
      u_usbdc_if.fifo_empty, u_usbdc_if.fifo_full, htx_ready, urx_ready,
      dma_irq, hrx_valid, utx_valid, u_usbdc_if.credit_valid});
    cr(3'h3, 8'h00);
    chk("reset_sched", 32'h0000FF00, d);
    close_out;
  end
endmodule
